// ==== bench/smbus_host_model.sv ====
// Bus master model: drives the bus clock and open-drain data line
`timescale 1ns/10ps
module smbus_host_model (
    // Bus pins, data released means driven high here
    output logic      o_scl,
    output logic      o_sda_drv,
    input  wire logic i_sda_wire
);
    initial begin
        o_scl     = 1'b1;
        o_sda_drv = 1'b1;
    end

    // One 64 ns bit slot; data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        o_sda_drv = b;
        #16 o_scl = 1'b1;
        #16 r = i_sda_wire;
        #16 o_scl = 1'b0;
        #16;
    endtask

    // Start and repeated start share one shape
    task automatic start();
        o_sda_drv = 1'b1;
        #16 o_scl = 1'b1;
        #16 o_sda_drv = 1'b0;
        #16 o_scl = 1'b0;
        #16;
    endtask

    // Clock is left standing high between frames
    task automatic stop();
        o_sda_drv = 1'b0;
        #16 o_scl = 1'b1;
        #16 o_sda_drv = 1'b1;
        #32;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack_n);
    endtask

    task automatic get_byte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask
endmodule // smbus_host_model

// ==== bench/temp_readout_tb.sv ====
// Self-checking bench for the temperature readout block
`timescale 1ns/10ps
module temp_readout_tb;
    import temp_readout_pkg::*;
    localparam logic [6:0] ADDR = SLAVE_ADDR_DEFAULT;
    logic              i_clk = 1'b0;
    logic              i_reset = 1'b1;
    logic              sleep_n = 1'b1;
    logic              fault = 1'b0;
    logic [MEAS_W-1:0] lmeas = 11'd202;
    logic [MEAS_W-1:0] rmeas = 11'd4;
    logic              scl, sda_host, sda_wire, o_sda, o_sda_oe_n;
    logic              busy, hw_sleep_input, series, a;
    logic [7:0]        d;
    int                mismatches = 0;
    int                checked = 0;
    int                cycles = 0;
    logic [7:0] idx_t [4] = '{IDX_LOCAL_MAIN, IDX_REMOTE_MAIN,
                              IDX_REMOTE_FRAC, IDX_LOCAL_FRAC};
    logic [7:0] exp_t [4] = '{8'h19, 8'h01, 8'h80, 8'h40};

    always #2 i_clk = ~i_clk;
    // Open-drain wire with pull-up
    assign sda_wire = sda_host & (o_sda_oe_n | o_sda);

    smbus_host_model i_host (.o_scl(scl), .o_sda_drv(sda_host),
        .i_sda_wire(sda_wire));

    temp_readout #(.CONV_CYCLES(32'd20), .RATE_BASE_CYCLES(32'd2560)) i_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_wire),
        .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
        .i_hw_sleep_input_n(sleep_n), .i_local_meas(lmeas),
        .i_remote_meas(rmeas), .i_remote_fault(fault), .o_conv_busy(busy),
        .o_standby(hw_sleep_input), .o_series_cancel(series));

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            $display("timeout after %0d cycles", cycles);
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Inputs move 1 ns after a rising edge, except that tick(0) only waits 1 ns
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic addr_idx(input logic [7:0] idx);
        tick(1);
        i_host.start();
        i_host.put_byte({ADDR, 1'b0}, a);
        chk("address ack", 8'h00, {7'h00, a});
        i_host.put_byte(idx, a);
        chk("index ack", 8'h00, {7'h00, a});
    endtask

    task automatic send(input logic [7:0] idx);
        addr_idx(idx);
        i_host.stop();
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] dat);
        addr_idx(idx);
        i_host.put_byte(dat, a);
        chk("data ack", 8'h00, {7'h00, a});
        i_host.stop();
    endtask

    task automatic rcv(output logic [7:0] v);
        i_host.start();
        i_host.put_byte({ADDR, 1'b1}, a);
        chk("read address ack", 8'h00, {7'h00, a});
        i_host.get_byte(v);
        i_host.stop();
    endtask

    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] v);
        addr_idx(idx);
        rcv(v);
    endtask

    initial begin
        tick(12);
        i_reset = 1'b0;
        tick(4);
        rcv(d);
        chk("receive after reset", 8'h19, d);
        for (int k = 0; k < 4; k++) begin
            rd_reg(idx_t[k], d);
            chk("temperature register", exp_t[k], d);
        end
        tick(1);
        rcv(d);
        chk("receive repeats index", 8'h40, d);
        wr_reg(IDX_LOCAL_MAIN, 8'hff);
        rd_reg(IDX_LOCAL_MAIN, d);
        chk("read-only main", 8'h19, d);
        tick(1);
        i_host.start();
        i_host.put_byte({ADDR ^ 7'h01, 1'b0}, a);
        chk("foreign address nack", 8'h01, {7'h00, a});
        i_host.stop();
        $display("test bus done");

        fault = 1'b1;
        tick(700);
        rd_reg(IDX_REMOTE_MAIN, d);
        chk("fault code", FAULT_CODE, d);
        rd_reg(IDX_STATUS, d);
        chk("status fault", 8'h08, d & 8'h08);
        fault = 1'b0;
        $display("test fault done");

        wr_reg(IDX_CFG_WR, 8'h40);
        chk("sw standby", 8'h01, {7'h00, hw_sleep_input});
        rd_reg(IDX_CFG_RD, d);
        chk("config readback", 8'h40, d);
        lmeas = 11'd80;
        tick(800);
        rd_reg(IDX_LOCAL_MAIN, d);
        chk("no autoconvert", 8'h19, d);
        send(IDX_ONE_SHOT);
        tick(40);
        rd_reg(IDX_LOCAL_MAIN, d);
        chk("sw one-shot", 8'h0a, d);
        chk("back in standby", 8'h01, {7'h00, hw_sleep_input});
        $display("test sw standby done");

        sleep_n = 1'b0;
        lmeas = 11'd160;
        send(IDX_ONE_SHOT);
        tick(100);
        chk("hw one-shot busy", 8'h00, {7'h00, busy});
        rd_reg(IDX_LOCAL_MAIN, d);
        chk("hw one-shot result", 8'h0a, d);
        wr_reg(IDX_CFG_WR, 8'h00);
        tick(1);
        sleep_n = 1'b1;
        lmeas = 11'd165;
        for (int k = 0; k < 700 && busy !== 1'b1; k++) tick(1);
        chk("conversion started", 8'h01, {7'h00, busy});
        tick(0);
        sleep_n = 1'b0;
        tick(40);
        chk("aborted busy", 8'h00, {7'h00, busy});
        rd_reg(IDX_LOCAL_MAIN, d);
        chk("aborted result", 8'h0a, d);
        $display("test hw standby done");

        sleep_n = 1'b1;
        tick(40);
        rd_reg(IDX_LOCAL_FRAC, d);
        chk("fraction slow", 8'ha0, d);
        wr_reg(IDX_CFG_WR, 8'h50);
        chk("series on", 8'h01, {7'h00, series});
        wr_reg(IDX_RATE_WR, 8'h05);
        chk("series off fast", 8'h00, {7'h00, series});
        rd_reg(IDX_RATE_RD, d);
        chk("rate readback", 8'h05, d);
        send(IDX_ONE_SHOT);
        // Host waits for busy to drop, then reads at once
        for (int k = 0; k < 100 && busy !== 1'b0; k++) tick(1);
        rd_reg(IDX_LOCAL_FRAC, d);
        chk("no fraction fast", 8'h00, d);
        $display("test rate done");
        report_and_stop();
    end
endmodule // temp_readout_tb

// ==== logic/temp_readout.sv ====
// Serial-bus slave, standby control and result registers of the sensor
//
// What this block does
// - Standby with converter off when sleep pin low or run/stop bit set.
// - Registers kept and serial bus fully alive in both standby kinds.
// - Under hardware standby a one-shot command starts no conversion.
// - Under software standby a one-shot still starts a conversion.
// - Sleep pin low overrides every software conversion request.
// - Standby during conversion aborts it; old results stay unchanged.
// - A normal conversion lasts 125 ms.
// - One slave address reaches every register and function.
// - Only write byte, read byte, send byte and receive byte.
// - Write: address+W, index, data; each acked, data stored.
// - Read: index, repeated start, address+R, one byte, master nacks.
// - Address plus index alone is a command, e.g. one-shot.
// - Address-only read returns register of the latest index byte.
// - Main byte is two's complement, 1 degree per step, MSB first.
// - Half a degree is added before truncation to round results.
// - Remote junction fault reports code 80h as remote temperature.
// - Local main at index 00h, remote main at 01h, any rate.
// - Fraction registers 10h remote, 11h local, top three bits eighths.
// - Fractions are provided only at 1 Hz or slower.
// - Main and fraction registers update independently of reads.
// - Configuration bit 4 selects series-resistance cancellation, at 1 Hz or slower only.
// - Busy bit set during conversion; old results remain readable.
// - Register index resets to zero.
// - One-shot during a running conversion is ignored.
// - Configuration bit 6 set is software standby, clear is autoconvert.
`timescale 1ns/10ps
module temp_readout #(
    parameter logic [6:0]  SLAVE_ADDR  = temp_readout_pkg::SLAVE_ADDR_DEFAULT,
    parameter logic [31:0] CONV_CYCLES = 32'(temp_readout_pkg::CONV_CYC),
    parameter logic [31:0] RATE_BASE_CYCLES =
        32'(temp_readout_pkg::RATE_BASE_CYC)
) (
    // Clock and reset
    input  wire logic                               i_clk,
    input  wire logic                               i_reset,
    // Serial bus pins, data is open drain
    input  wire logic                               i_scl,
    input  wire logic                               i_sda,
    output logic                                    o_sda,
    output logic                                    o_sda_oe_n,
    // Hardware standby pin
    input  wire logic                               i_hw_sleep_input_n,
    // Measurement front end, eighths of a degree
    input  wire logic [temp_readout_pkg::MEAS_W-1:0] i_local_meas,
    input  wire logic [temp_readout_pkg::MEAS_W-1:0] i_remote_meas,
    input  wire logic                               i_remote_fault,
    // Status
    output logic                                    o_conv_busy,
    output logic                                    o_standby,
    output logic                                    o_series_cancel
);
    import temp_readout_pkg::*;

    logic       scl_m_r, scl_s_r, scl_d_r;
    logic       sda_m_r, sda_s_r, sda_d_r;
    logic       hw_m_r, hw_s_r;
    bus_state_e state_r;
    logic [7:0] shift_r;
    logic [2:0] bit_r;
    logic       byte_done_r;
    logic       read_r;
    logic [1:0] rx_cnt_r;
    logic       oe_n_r;
    logic       one_shot_r;
    logic       reg_wr_r;
    logic [7:0] index_r;
    logic [7:0] cfg_r;
    logic [7:0] rate_r;
    logic       busy_r;
    logic [31:0] conv_cnt_r;
    logic [31:0] rate_cnt_r;
    logic [7:0] local_main_r, remote_main_r;
    logic [7:0] local_frac_r, remote_frac_r;
    logic       fault_r;
    logic       standby_r;
    logic       series_r;
    logic       sda_low_r;

    // Rounds eighths to whole degrees, saturating at the top of the range
    function automatic logic [7:0] round_main(input logic [MEAS_W-1:0] m);
        logic [11:0] sum;
        sum = {m[MEAS_W-1], m} + ROUND_HALF;
        round_main = (sum[11] != sum[10]) ? TEMP_MAX : sum[10:3];
    endfunction

    // Pins pass two flops; the third stage only serves edge detection
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            hw_m_r  <= 1'b1;
            hw_s_r  <= 1'b1;
        end else begin
            scl_m_r <= i_scl;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= i_sda;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            hw_m_r  <= i_hw_sleep_input_n;
            hw_s_r  <= hw_m_r;
        end
    end

    wire scl_rise   = scl_s_r & ~scl_d_r;
    wire scl_fall   = ~scl_s_r & scl_d_r;
    wire bus_start  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    wire bus_stop   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    wire addr_match = (shift_r[7:1] == SLAVE_ADDR);
    wire [2:0] rate_code = (rate_r > {5'h00, RATE_MAX}) ? RATE_MAX
                                                        : rate_r[2:0];
    wire ext_en      = (rate_code <= RATE_EXT_MAX);
    wire hw_standby  = ~hw_s_r;
    wire sw_standby  = cfg_r[CFG_RUN_STOP_BIT];
    wire cfg_wr      = reg_wr_r && (index_r == IDX_CFG_WR);
    wire rate_wr     = reg_wr_r && (index_r == IDX_RATE_WR);
    wire stop_req    = cfg_wr && shift_r[CFG_RUN_STOP_BIT] && !sw_standby;
    wire abort       = busy_r & (hw_standby | stop_req);
    wire auto_due    = ~sw_standby & (rate_cnt_r == 32'h0);
    wire conv_start  = ~hw_standby & ~busy_r & (one_shot_r | auto_due);
    wire conv_done   = busy_r & ~abort & (conv_cnt_r == 32'h1);
    wire [31:0] rate_period = RATE_BASE_CYCLES >> rate_code;
    wire [7:0] status_byte = (8'(busy_r) << STAT_BUSY_BIT)
                           | (8'(fault_r) << STAT_FAULT_BIT);
    wire [7:0] read_data =
        (index_r == IDX_LOCAL_MAIN)  ? local_main_r  :
        (index_r == IDX_REMOTE_MAIN) ? remote_main_r :
        (index_r == IDX_STATUS)      ? status_byte   :
        (index_r == IDX_CFG_RD)      ? cfg_r         :
        (index_r == IDX_RATE_RD)     ? rate_r        :
        (index_r == IDX_REMOTE_FRAC) ? remote_frac_r :
        (index_r == IDX_LOCAL_FRAC)  ? local_frac_r  : 8'h00;

    // Bus slave; oe_n low pulls the data line low
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r     <= ST_IDLE;
            shift_r     <= 8'h00;
            bit_r       <= 3'h0;
            byte_done_r <= 1'b0;
            read_r      <= 1'b0;
            rx_cnt_r    <= 2'h0;
            oe_n_r      <= 1'b1;
            one_shot_r  <= 1'b0;
            reg_wr_r    <= 1'b0;
            index_r     <= INDEX_RESET;
        end else begin
            one_shot_r <= 1'b0;
            reg_wr_r   <= 1'b0;
            if (bus_start) begin
                state_r     <= ST_ADDR;
                bit_r       <= 3'h0;
                byte_done_r <= 1'b0;
                rx_cnt_r    <= 2'h0;
                oe_n_r      <= 1'b1;
            end else if (bus_stop) begin
                state_r <= ST_IDLE;
                oe_n_r  <= 1'b1;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                    end
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            shift_r     <= {shift_r[6:0], sda_s_r};
                            bit_r       <= bit_r + 3'h1;
                            byte_done_r <= (bit_r == 3'h7);
                        end else if (scl_fall && byte_done_r) begin
                            byte_done_r <= 1'b0;
                            if (state_r == ST_ADDR) begin
                                if (addr_match) begin
                                    state_r <= ST_ADDR_ACK;
                                    oe_n_r  <= 1'b0;
                                    read_r  <= shift_r[0];
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end else if (rx_cnt_r != RX_BYTES_MAX) begin
                                state_r  <= ST_RX_ACK;
                                oe_n_r   <= 1'b0;
                                rx_cnt_r <= rx_cnt_r + 2'h1;
                                if (rx_cnt_r == 2'h0) begin
                                    index_r    <= shift_r;
                                    one_shot_r <= (shift_r == IDX_ONE_SHOT);
                                end else begin
                                    reg_wr_r <= 1'b1;
                                end
                            end else begin
                                // A third byte is not a supported protocol
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_r <= 3'h0;
                            if (read_r) begin
                                state_r <= ST_TX;
                                shift_r <= read_data;
                                oe_n_r  <= read_data[7];
                            end else begin
                                state_r <= ST_RX;
                                oe_n_r  <= 1'b1;
                            end
                        end
                    end
                    ST_RX_ACK: begin
                        if (scl_fall) begin
                            state_r <= ST_RX;
                            oe_n_r  <= 1'b1;
                            bit_r   <= 3'h0;
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_r == 3'h7) begin
                                state_r <= ST_TX_ACK;
                                oe_n_r  <= 1'b1;
                            end else begin
                                bit_r   <= bit_r + 3'h1;
                                shift_r <= {shift_r[6:0], 1'b0};
                                oe_n_r  <= shift_r[6];
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        // One byte per read; the master's ack bit ends it
                        if (scl_rise) begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                        oe_n_r  <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Writable registers stay reachable in standby
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_r  <= CFG_RESET;
            rate_r <= RATE_RESET;
        end else begin
            if (cfg_wr) begin
                cfg_r <= shift_r;
            end
            if (rate_wr) begin
                rate_r <= shift_r;
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            busy_r     <= 1'b0;
            conv_cnt_r <= 32'h0;
            rate_cnt_r <= 32'h0;
        end else begin
            if (conv_start) begin
                busy_r     <= 1'b1;
                conv_cnt_r <= CONV_CYCLES;
            end else if (abort || conv_done) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                conv_cnt_r <= conv_cnt_r - 32'h1;
            end
            // A one-shot in run mode restarts the full rate delay
            if (conv_start) begin
                rate_cnt_r <= rate_period;
            end else if (rate_cnt_r != 32'h0) begin
                rate_cnt_r <= rate_cnt_r - 32'h1;
            end
        end
    end

    // Results latch only at a completed conversion
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            local_main_r  <= TEMP_RESET;
            remote_main_r <= TEMP_RESET;
            local_frac_r  <= TEMP_RESET;
            remote_frac_r <= TEMP_RESET;
            fault_r       <= 1'b0;
        end else if (conv_done) begin
            local_main_r  <= round_main(i_local_meas);
            remote_main_r <= i_remote_fault ? FAULT_CODE
                             : round_main(i_remote_meas);
            // Fractions are raw eighths, not offset by the rounding half
            local_frac_r  <= ext_en ? {i_local_meas[2:0], 5'h00}
                                    : TEMP_RESET;
            remote_frac_r <= (ext_en && !i_remote_fault)
                             ? {i_remote_meas[2:0], 5'h00} : TEMP_RESET;
            fault_r       <= i_remote_fault;
        end
    end

    // Output flops
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            standby_r <= 1'b0;
            series_r  <= 1'b0;
            sda_low_r <= 1'b0;
        end else begin
            standby_r <= hw_standby | sw_standby;
            series_r  <= cfg_r[CFG_SERIES_BIT] & ext_en;
            sda_low_r <= 1'b0;
        end
    end

    assign o_sda           = sda_low_r;
    assign o_sda_oe_n      = oe_n_r;
    assign o_conv_busy     = busy_r;
    assign o_standby       = standby_r;
    assign o_series_cancel = series_r;

    sequence s_conv_end;
        busy_r && !abort && conv_cnt_r == 32'h1;
    endsequence

    sequence s_oneshot_sw;
        one_shot_r && sw_standby && !hw_standby && !busy_r;
    endsequence

    a_hw_blocks_start: assert property (@(posedge i_clk) disable iff (i_reset)
        hw_standby |=> !$rose(busy_r))
        else $error("conversion started under hardware standby");

    a_hw_aborts: assert property (@(posedge i_clk) disable iff (i_reset)
        busy_r && hw_standby |=> !busy_r)
        else $error("hardware standby did not stop conversion");

    a_abort_keeps: assert property (@(posedge i_clk) disable iff (i_reset)
        abort |=> $stable(local_main_r) && $stable(remote_main_r))
        else $error("aborted conversion changed results");

    a_oneshot_sw: assert property (@(posedge i_clk) disable iff (i_reset)
        s_oneshot_sw |=> busy_r && conv_cnt_r == CONV_CYCLES)
        else $error("one-shot ignored in software standby");

    a_oneshot_busy: assert property (@(posedge i_clk) disable iff (i_reset)
        one_shot_r && busy_r && !abort && conv_cnt_r > 32'h1
        |=> conv_cnt_r == $past(conv_cnt_r) - 32'h1)
        else $error("one-shot restarted a running conversion");

    a_conv_load: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(busy_r) |-> conv_cnt_r == CONV_CYCLES)
        else $error("conversion length not loaded");

    a_fault_code: assert property (@(posedge i_clk) disable iff (i_reset)
        s_conv_end ##0 i_remote_fault |=> remote_main_r == FAULT_CODE)
        else $error("remote fault code not reported");

    a_ext_gated: assert property (@(posedge i_clk) disable iff (i_reset)
        s_conv_end ##0 !ext_en |=> local_frac_r == 8'h00)
        else $error("fraction given at a fast rate");

    a_busy_holds: assert property (@(posedge i_clk) disable iff (i_reset)
        busy_r && !conv_done |=> $stable(local_main_r))
        else $error("results changed mid conversion");

    a_addr_ack: assert property (@(posedge i_clk) disable iff (i_reset)
        state_r == ST_ADDR_ACK |-> !oe_n_r)
        else $error("address not acknowledged");

    a_tx_release: assert property (@(posedge i_clk) disable iff (i_reset)
        state_r == ST_TX ##1 state_r == ST_TX_ACK |-> oe_n_r)
        else $error("data line held in master ack slot");

endmodule // temp_readout

// ==== logic/temp_readout_pkg.sv ====
// Constants, register map and bus states for the temperature readout block
package temp_readout_pkg;

    // Register indices
    localparam logic [7:0] IDX_LOCAL_MAIN  = 8'h00;
    localparam logic [7:0] IDX_REMOTE_MAIN = 8'h01;
    localparam logic [7:0] IDX_STATUS      = 8'h02;
    localparam logic [7:0] IDX_CFG_RD      = 8'h03;
    localparam logic [7:0] IDX_RATE_RD     = 8'h04;
    localparam logic [7:0] IDX_CFG_WR      = 8'h09;
    localparam logic [7:0] IDX_RATE_WR     = 8'h0a;
    localparam logic [7:0] IDX_ONE_SHOT    = 8'h0f;
    localparam logic [7:0] IDX_REMOTE_FRAC = 8'h10;
    localparam logic [7:0] IDX_LOCAL_FRAC  = 8'h11;

    // Field positions
    localparam int CFG_RUN_STOP_BIT = 6;
    localparam int CFG_SERIES_BIT   = 4;
    localparam int STAT_BUSY_BIT    = 7;
    localparam int STAT_FAULT_BIT   = 3;
    localparam int FRAC_LSB         = 5;

    // Values after reset and fixed codes
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET   = 8'h00;
    localparam logic [7:0] RATE_RESET  = 8'h02;
    localparam logic [7:0] TEMP_RESET  = 8'h00;
    localparam logic [7:0] FAULT_CODE  = 8'h80;
    localparam logic [7:0] TEMP_MAX    = 8'h7f;
    localparam logic [2:0] RATE_MAX    = 3'h7;
    localparam logic [2:0] RATE_EXT_MAX = 3'h4;
    localparam logic [11:0] ROUND_HALF = 12'h004;
    localparam logic [1:0] RX_BYTES_MAX = 2'h2;

    // Slave address, arbitrary value
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2a;

    // Timing
    localparam int    CLK_MHZ        = 250;
    localparam int    CONV_TIME_MS   = 125;
    localparam int    CONV_CYC       = CONV_TIME_MS * 1000 * CLK_MHZ;
    localparam int    RATE_BASE_S    = 16;
    localparam longint RATE_BASE_CYC = longint'(RATE_BASE_S) * 1000000
                                       * longint'(CLK_MHZ);

    localparam int MEAS_W = 11;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_RX       = 3'b010,
        ST_RX_ACK   = 3'b110,
        ST_TX       = 3'b111,
        ST_TX_ACK   = 3'b101
    } bus_state_e;

endpackage
